// [hw/acd_pkg.sv]
// Package of constants, offsets and types for the overlay/diagnostic/flush command block.
package acd_pkg;

  // ----------------------------------------------------------------
  // Task-file register indices (software port addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_ERROR    = 4'h1;
  localparam logic [3:0] ADDR_FEATURE  = 4'h1;
  localparam logic [3:0] ADDR_SECCNT   = 4'h2;
  localparam logic [3:0] ADDR_SECNUM   = 4'h3;
  localparam logic [3:0] ADDR_CYLLO    = 4'h4;
  localparam logic [3:0] ADDR_CYLHI    = 4'h5;
  localparam logic [3:0] ADDR_STATUS   = 4'h7;
  localparam logic [3:0] ADDR_COMMAND  = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
  localparam logic [3:0] ADDR_OVL_CTRL = 4'hA;

  // ----------------------------------------------------------------
  // Command and subcommand codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DIAG   = 8'h90;
  localparam logic [7:0] CMD_FLUSH  = 8'hE7;
  localparam logic [7:0] CMD_OVL    = 8'hB1;
  localparam logic [7:0] SUB_FIRST  = 8'hC0;
  localparam logic [7:0] SUB_LAST   = 8'hC3;
  localparam logic [7:0] SUB_FREEZE = 8'hC1;

  // ----------------------------------------------------------------
  // Overlay rejection reason codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RSN_FROZEN   = 8'h01;
  localparam logic [7:0] RSN_SEC_LOCK = 8'h02;
  localparam logic [7:0] RSN_MODIFIED = 8'h03;
  localparam logic [7:0] RSN_DISABLE  = 8'h04;
  localparam logic [7:0] RSN_MAX_LOCK = 8'h05;
  localparam logic [7:0] RSN_HPA      = 8'h06;
  localparam logic [7:0] RSN_UNSUPP   = 8'h07;
  localparam logic [7:0] RSN_BAD_SUB  = 8'h08;
  localparam logic [7:0] RSN_OTHER    = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_BSY  = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_ERR  = 0;
  localparam int ER_ABT  = 2;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;
  localparam int CTL_UNSUPP   = 0;
  localparam int CTL_SEC_LOCK = 1;
  localparam int CTL_MODIFIED = 2;
  localparam int CTL_MAX_LOCK = 3;
  localparam int CTL_HPA      = 4;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ZERO8        = 8'h00;
  localparam logic [1:0] IRQ_ZERO     = 2'h0;
  localparam int         CLK_MHZ      = 20;
  localparam int         DIAG_TIME_US = 2;
  localparam int         DIAG_CYCLES  = DIAG_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ACD_IDLE,
    ACD_DIAG,
    ACD_FLUSH,
    ACD_OVL,
    ACD_DONE
  } acd_state_t;

endpackage

// [hw/acd_cnt.sv]
// Down counter used to time the internal self-test.
`timescale 1ns/1ps
module acd_cnt
  import acd_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_load,
  input  wire logic [7:0] i_value,
  output logic            o_zero
);
  logic [7:0] cnt_q;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_q <= ZERO8;
    else if (i_load)
      cnt_q <= i_value;
    else if (cnt_q != ZERO8)
      cnt_q <= cnt_q - 8'h01;
  end

  assign o_zero = (cnt_q == ZERO8);
endmodule

// [hw/acd_sync.sv]
// Three-stage synchroniser for a level arriving from another clock domain.
`timescale 1ns/1ps
module acd_sync
(
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_level
);
  logic [2:0] sh_q;

  // A change is accepted only when stages two and three agree.
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sh_q    <= 3'h0;
      o_level <= 1'b0;
    end
    else
    begin
      sh_q <= {sh_q[1:0], i_async};
      if (sh_q[1] == sh_q[2])
        o_level <= sh_q[2];
    end
  end
endmodule

// [hw/acd_core.sv]
// Command interpreter: overlay rejection reporting, self-test and cache flush.
//
// Behaviour
// - Rejected overlay subcommand aborts; reason to sector count, word to cylinder high.
// - Offending bit position low half to cylinder low, high half to sector number.
// - Reason 01h when the overlay feature is frozen.
// - Reason 02h when security holds the device locked.
// - Reason 03h when features were already altered by an overlay.
// - Reason 04h when the host tries disabling an enabled feature.
// - Reason 05h when the maximum-address setting is locked or frozen.
// - Reason 06h when a host protected area is established.
// - Reason 07h when overlay operation is not supported.
// - Reason 08h for unknown subcommand, FFh for any other cause.
// - Command 90h starts the internal self-test.
// - After self-test the Error register holds the diagnostic code.
// - Command E7h flushes every pending write-cache entry to media.
// - Flush completes only after the write cache is fully committed.
// - Feature values C0h to C3h are subcommands; others reserved.
`timescale 1ns/1ps
module acd_core
  import acd_pkg::*;
#(
  parameter logic [7:0] DIAG_CODE = 8'h01
)
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_cache_empty,
  output logic            o_flush_req,
  input  wire logic       i_ovl_reject,
  input  wire logic       i_ovl_disable,
  input  wire logic [7:0] i_ovl_word,
  input  wire logic [15:0] i_ovl_bit,
  output logic            o_ovl_start,
  output logic            o_irq
);
  import acd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acd_state_t  state_q;
  logic [7:0]  feature_q;
  logic [7:0]  error_q;
  logic [7:0]  status_q;
  logic [7:0]  seccnt_q;
  logic [7:0]  secnum_q;
  logic [7:0]  cyllo_q;
  logic [7:0]  cylhi_q;
  logic [4:0]  ctl_q;
  logic        frozen_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic        ovl_start_q;
  logic        flush_req_q;
  logic [7:0]  rdata_q;
  logic        cache_empty;
  logic        diag_zero;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire         cmd_wr      = i_wr && (i_addr == ADDR_COMMAND) && (state_q == ACD_IDLE);
  wire         cmd_diag    = cmd_wr && (i_wdata == CMD_DIAG);
  wire         cmd_flush   = cmd_wr && (i_wdata == CMD_FLUSH);
  wire         cmd_ovl     = cmd_wr && (i_wdata == CMD_OVL);
  wire         sub_valid   = (feature_q >= SUB_FIRST) && (feature_q <= SUB_LAST);
  wire         diag_load   = cmd_diag;
  wire         ev_done     = (state_q == ACD_DONE);
  wire         irq_clr_wr  = i_wr && (i_addr == ADDR_IRQ_STAT);
  wire [1:0]   irq_clr     = irq_clr_wr ? i_wdata[1:0] : IRQ_ZERO;
  wire         abort_now;
  wire [7:0]   reason;

  // Checked in priority order; the first matching cause is reported.
  assign reason =
    ctl_q[CTL_UNSUPP]   ? RSN_UNSUPP   :
    !sub_valid          ? RSN_BAD_SUB  :
    frozen_q            ? RSN_FROZEN   :
    ctl_q[CTL_SEC_LOCK] ? RSN_SEC_LOCK :
    ctl_q[CTL_MAX_LOCK] ? RSN_MAX_LOCK :
    ctl_q[CTL_HPA]      ? RSN_HPA      :
    ctl_q[CTL_MODIFIED] ? RSN_MODIFIED :
    i_ovl_disable       ? RSN_DISABLE  :
                          RSN_OTHER;

  wire         local_rej   = ctl_q[CTL_UNSUPP] || !sub_valid || frozen_q
                             || ctl_q[CTL_SEC_LOCK] || ctl_q[CTL_MAX_LOCK] || ctl_q[CTL_HPA]
                             || ctl_q[CTL_MODIFIED];
  assign abort_now = (state_q == ACD_OVL) && (local_rej || i_ovl_reject);

  wire [7:0]   rd_mux =
    (i_addr == ADDR_ERROR)    ? error_q  :
    (i_addr == ADDR_SECCNT)   ? seccnt_q :
    (i_addr == ADDR_SECNUM)   ? secnum_q :
    (i_addr == ADDR_CYLLO)    ? cyllo_q  :
    (i_addr == ADDR_CYLHI)    ? cylhi_q  :
    (i_addr == ADDR_STATUS)   ? status_q :
    (i_addr == ADDR_IRQ_STAT) ? {6'h00, irq_stat_q} :
    (i_addr == ADDR_IRQ_MASK) ? {6'h00, irq_mask_q} :
    (i_addr == ADDR_OVL_CTRL) ? {3'h0, ctl_q}       :
                                ZERO8;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  acd_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (i_cache_empty),
    .o_level   (cache_empty)
  );

  acd_cnt u_cnt (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_load    (diag_load),
    .i_value   (8'(DIAG_CYCLES)),
    .o_zero    (diag_zero)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_q <= ACD_IDLE;
    else
    begin
      unique case (state_q)
        ACD_IDLE:
          if (cmd_diag)
            state_q <= ACD_DIAG;
          else if (cmd_flush)
            state_q <= ACD_FLUSH;
          else if (cmd_ovl)
            state_q <= ACD_OVL;
        ACD_DIAG:
          if (diag_zero)
            state_q <= ACD_DONE;
        ACD_FLUSH:
          if (cache_empty && !flush_req_q)
            state_q <= ACD_DONE;
        ACD_OVL:
          state_q <= ACD_DONE;
        ACD_DONE:
          state_q <= ACD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Task-file result registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      error_q  <= ZERO8;
      status_q <= STATUS_RESET;
      seccnt_q <= ZERO8;
      secnum_q <= ZERO8;
      cyllo_q  <= ZERO8;
      cylhi_q  <= ZERO8;
    end
    else if (cmd_wr && (cmd_diag || cmd_flush || cmd_ovl))
    begin
      status_q          <= STATUS_RESET;
      status_q[ST_BSY]  <= 1'b1;
    end
    else if (abort_now)
    begin
      error_q           <= ZERO8;
      error_q[ER_ABT]   <= 1'b1;
      status_q[ST_ERR]  <= 1'b1;
      seccnt_q          <= reason;
      cylhi_q           <= i_ovl_word;
      cyllo_q           <= i_ovl_bit[7:0];
      secnum_q          <= i_ovl_bit[15:8];
    end
    else if ((state_q == ACD_DIAG) && diag_zero)
      error_q <= DIAG_CODE;
    else if ((state_q == ACD_OVL) || ((state_q == ACD_FLUSH) && cache_empty && !flush_req_q))
      error_q <= ZERO8;
    else if (ev_done)
      status_q[ST_BSY] <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Feature, overlay controls, freeze lock
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      feature_q <= ZERO8;
      ctl_q     <= 5'h00;
      frozen_q  <= 1'b0;
    end
    else
    begin
      if (i_wr && (i_addr == ADDR_FEATURE))
        feature_q <= i_wdata;
      if (i_wr && (i_addr == ADDR_OVL_CTRL))
        ctl_q <= i_wdata[4:0];
      // A successful freeze lock makes every later overlay subcommand abort.
      if ((state_q == ACD_OVL) && !abort_now && (feature_q == SUB_FREEZE))
        frozen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Side requests, interrupts and read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flush_req_q <= 1'b0;
      ovl_start_q <= 1'b0;
      irq_stat_q  <= IRQ_ZERO;
      irq_mask_q  <= IRQ_ZERO;
      o_irq       <= 1'b0;
      rdata_q     <= ZERO8;
    end
    else
    begin
      // Request stays up until the cache reports drained, so no entry is left behind.
      flush_req_q <= cmd_flush || (flush_req_q && !cache_empty);
      ovl_start_q <= cmd_ovl;
      if (i_wr && (i_addr == ADDR_IRQ_MASK))
        irq_mask_q <= i_wdata[1:0];
      // Set wins over a same-cycle clear.
      irq_stat_q[IRQ_DONE]  <= ev_done   || (irq_stat_q[IRQ_DONE]  && !irq_clr[IRQ_DONE]);
      irq_stat_q[IRQ_ABORT] <= abort_now || (irq_stat_q[IRQ_ABORT] && !irq_clr[IRQ_ABORT]);
      o_irq   <= |(irq_stat_q & irq_mask_q);
      rdata_q <= i_rd ? rd_mux : ZERO8;
    end
  end

  assign o_rdata     = rdata_q;
  assign o_flush_req = flush_req_q;
  assign o_ovl_start = ovl_start_q;
endmodule

// [bench/acd_chk.sv]
// Port-level assertions for the command block.
`timescale 1ns/1ps
module acd_chk
  import acd_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_cache_empty,
  input wire logic       o_flush_req,
  input wire logic       o_ovl_start,
  input wire logic       o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  wire cmd_wr = i_wr && i_addr == ADDR_COMMAND;

  a_rdata_slot: assert property (!$past(i_rd) |-> o_rdata == ZERO8)
    else $error("read data outside its slot");
  a_flush_cause: assert property ($rose(o_flush_req) |-> $past(cmd_wr && i_wdata == CMD_FLUSH))
    else $error("flush request without flush command");
  a_flush_hold: assert property (o_flush_req && !i_cache_empty |=> o_flush_req)
    else $error("flush request dropped with dirty cache");
  a_flush_done: assert property ($fell(o_flush_req) |-> i_cache_empty && $past(i_cache_empty, 3))
    else $error("flush ended before cache settled empty");
  a_busy_read: assert property ($past(i_rd && i_addr == ADDR_STATUS && o_flush_req) |-> o_rdata[ST_BSY])
    else $error("status not busy during flush");
  a_ovl_pulse: assert property (o_ovl_start |-> $past(cmd_wr && i_wdata == CMD_OVL) ##1 !o_ovl_start)
    else $error("overlay start pulse wrong");
  a_ovl_alone: assert property (o_ovl_start |-> !o_flush_req)
    else $error("overlay start during flush");
  a_irq_masked: assert property (i_wr && i_addr == ADDR_IRQ_MASK && i_wdata == ZERO8 |-> ##2 !o_irq)
    else $error("interrupt high with all masked");
endmodule

bind acd_core acd_chk acd_chk_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cache_empty(i_cache_empty),
  .o_flush_req(o_flush_req), .o_ovl_start(o_ovl_start), .o_irq(o_irq));

// [bench/acd_cache_model.sv]
// Write cache and media stand-in that drains dirty lines only during a flush.
`timescale 1ns/1ps
module acd_cache_model
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_fill,
  input  wire logic [7:0] i_lines,
  input  wire logic [7:0] i_slow,
  input  wire logic       i_flush_req,
  output logic            o_cache_empty
);
  logic [7:0] lines_q;
  logic [7:0] wait_q;

  // The flag moves off the edge, as it would coming from the media clock.
  assign #7 o_cache_empty = (lines_q == 8'h00);

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lines_q <= 8'h00;
      wait_q  <= 8'h00;
    end
    else if (i_fill)
    begin
      lines_q <= i_lines;
      wait_q  <= i_slow;
    end
    else if (i_flush_req && lines_q != 8'h00)
    begin
      wait_q <= (wait_q == 8'h00) ? i_slow : wait_q - 8'h01;
      if (wait_q == 8'h00)
        lines_q <= lines_q - 8'h01;
    end
  end
endmodule

// [bench/test_acd_core.sv]
// Self-checking bench for the command block.
`timescale 1ns/1ps
module test_acd_core;
  import acd_pkg::*;
  localparam logic [7:0] DCODE = 8'h5A;
  logic        i_clk_sys = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [3:0]  i_addr    = 4'h0;
  logic [7:0]  i_wdata   = 8'h00;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        rej       = 1'b0;
  logic        dis       = 1'b0;
  logic [7:0]  word      = 8'h00;
  logic [15:0] bits      = 16'h0000;
  logic        fill      = 1'b1;
  logic [7:0]  lines     = 8'h00;
  logic [7:0]  slow      = 8'h00;
  logic [7:0]  o_rdata;
  logic        cache_empty;
  logic        o_flush_req;
  logic        o_irq;
  logic        ovl_start;
  int          n_errors  = 0;
  int          n_tests   = 0;
  int          cycles    = 0;

  always #25 i_clk_sys = ~i_clk_sys;

  acd_core #(.DIAG_CODE(DCODE)) acd_core_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cache_empty(cache_empty), .o_flush_req(o_flush_req), .i_ovl_reject(rej),
    .i_ovl_disable(dis), .i_ovl_word(word), .i_ovl_bit(bits), .o_ovl_start(ovl_start),
    .o_irq(o_irq));
  acd_cache_model acd_cache_model_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_fill(fill),
    .i_lines(lines), .i_slow(slow), .i_flush_req(o_flush_req), .o_cache_empty(cache_empty));

  task automatic give_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask

  // Polls status, bounded so a stuck busy flag ends in a mismatch.
  task automatic wait_idle;
    logic [7:0] v;
    v = 8'hFF;
    for (int k = 0; k < 300 && v[ST_BSY] !== 1'b0; k++)
      rd(ADDR_STATUS, v);
    chk1("idle", 1'b0, v[ST_BSY]);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_diag;
    logic [7:0] v;
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_COMMAND, CMD_DIAG);
    wr(ADDR_COMMAND, CMD_FLUSH);
    rd(ADDR_STATUS, v);
    chk1("busy", 1'b1, v[ST_BSY]);
    chk1("flush refused", 1'b0, o_flush_req);
    wait_idle();
    rdc("diag code", ADDR_ERROR, DCODE);
    rdc("irq done", ADDR_IRQ_STAT, 8'h01);
    chk1("irq on", 1'b1, o_irq);
    wr(ADDR_IRQ_MASK, 8'h00);
    @(posedge i_clk_sys);
    #1 chk1("irq masked", 1'b0, o_irq);
    wr(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h03);
    rdc("irq cleared", ADDR_IRQ_STAT, 8'h00);
    chk1("irq off", 1'b0, o_irq);
  endtask

  task automatic t_flush(input logic [7:0] n, input logic [7:0] s);
    logic [7:0] v;
    @(posedge i_clk_sys);
    fill  <= 1'b1;
    lines <= n;
    slow  <= s;
    @(posedge i_clk_sys);
    fill <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    wr(ADDR_COMMAND, CMD_FLUSH);
    #1 chk1("flush req", 1'b1, o_flush_req);
    rd(ADDR_STATUS, v);
    chk1("flush busy", 1'b1, v[ST_BSY]);
    wait_idle();
    chk1("cache empty", 1'b1, cache_empty);
    rdc("flush error", ADDR_ERROR, ZERO8);
  endtask

  task automatic t_ovl(input logic [7:0] f, input logic [7:0] c, input logic d, input logic [7:0] r);
    @(posedge i_clk_sys);
    rej  <= (r != ZERO8);
    dis  <= d;
    word <= r ^ 8'h30;
    bits <= {r, ~r};
    wr(ADDR_OVL_CTRL, c);
    wr(ADDR_FEATURE, f);
    wr(ADDR_COMMAND, CMD_OVL);
    #1 chk1("ovl start", 1'b1, ovl_start);
    wait_idle();
    if (r == ZERO8)
      rdc("ovl accepted", ADDR_ERROR, ZERO8);
    else
    begin
      rdc("reason", ADDR_SECCNT, r);
      rdc("word", ADDR_CYLHI, r ^ 8'h30);
      rdc("bit low", ADDR_CYLLO, ~r);
      rdc("bit high", ADDR_SECNUM, r);
      rdc("abort", ADDR_ERROR, 8'h04);
      rdc("err status", ADDR_STATUS, 8'h51);
    end
  endtask

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    fill      <= 1'b0;
    rdc("status reset", ADDR_STATUS, STATUS_RESET);
    rdc("unmapped", 4'hF, ZERO8);
    t_diag();
    t_flush(8'h04, 8'h03);
    t_flush(8'h01, 8'h00);
    t_ovl(8'hC4, 8'h01, 1'b0, RSN_UNSUPP);
    t_ovl(8'hC4, 8'h00, 1'b0, RSN_BAD_SUB);
    t_ovl(8'hBF, 8'h00, 1'b0, RSN_BAD_SUB);
    t_ovl(8'hC3, 8'h02, 1'b0, RSN_SEC_LOCK);
    t_ovl(8'hC3, 8'h08, 1'b0, RSN_MAX_LOCK);
    t_ovl(8'hC0, 8'h10, 1'b0, RSN_HPA);
    t_ovl(8'hC2, 8'h04, 1'b0, RSN_MODIFIED);
    t_ovl(8'hC3, 8'h00, 1'b1, RSN_DISABLE);
    t_ovl(8'hC3, 8'h00, 1'b0, RSN_OTHER);
    t_ovl(8'hC1, 8'h00, 1'b0, ZERO8);
    t_ovl(8'hC2, 8'h00, 1'b0, RSN_FROZEN);
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rdc("status rereset", ADDR_STATUS, STATUS_RESET);
    give_verdict();
  end
endmodule
